// file: verilog/line_unit_pkg.sv
// Purpose: Shared constants, register map and carriers of the line unit
//          interrupt mask and status block.
// Assumes: Word-indexed map; byte address is four times the index.
// Notes:   Reserved bits keep their reset value and ignore writes.
package line_unit_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W    = 12;            // Byte address width
  localparam int DATA_W    = 32;            // APB data width
  localparam int REG_W     = 8;             // Register width
  localparam int REG_LSB   = 2;             // Word index starts here
  localparam int REG_IDX_W = 6;             // Register index inside block
  localparam int CHAN_LSB  = REG_LSB + REG_IDX_W;
  localparam int CHAN_W    = 4;             // Channel block index
  localparam int MAX_CHAN  = 16;            // Channel blocks in the map

  ////////////////////////////////////////////////////////////////////////
  // Register indices inside one channel block
  localparam logic [REG_IDX_W-1:0] IDX_EDGE_SELECT = 6'h1a;
  localparam logic [REG_IDX_W-1:0] IDX_MASK_ZERO   = 6'h1b;
  localparam logic [REG_IDX_W-1:0] IDX_MASK_ONE    = 6'h1c;
  localparam logic [REG_IDX_W-1:0] IDX_MASK_TWO    = 6'h1d;
  localparam logic [REG_IDX_W-1:0] IDX_LIVE_ZERO   = 6'h1e;
  localparam logic [REG_IDX_W-1:0] IDX_LIVE_ONE    = 6'h1f;
  localparam logic [REG_IDX_W-1:0] IDX_LATCH_ZERO  = 6'h20;
  localparam logic [REG_IDX_W-1:0] IDX_LATCH_ONE   = 6'h21;
  localparam logic [REG_IDX_W-1:0] IDX_LATCH_TWO   = 6'h22;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and usable bits
  localparam logic [REG_W-1:0] MASK_ZERO_RST   = 8'hff;
  localparam logic [REG_W-1:0] MASK_ONE_RST    = 8'hef;
  localparam logic [REG_W-1:0] MASK_TWO_RST    = 8'h3f;
  localparam logic [REG_W-1:0] EDGE_SELECT_RST = 8'h00;
  localparam logic [REG_W-1:0] STATUS_RST      = 8'h00;
  localparam logic [REG_W-1:0] MASK_ZERO_BITS  = 8'hff;
  localparam logic [REG_W-1:0] MASK_ONE_BITS   = 8'he3;
  localparam logic [REG_W-1:0] MASK_TWO_BITS   = 8'h3f;
  localparam logic [REG_W-1:0] EDGE_SEL_BITS   = 8'h7f;
  localparam logic [REG_W-1:0] LIVE_ZERO_BITS  = 8'h9f;
  localparam logic [REG_W-1:0] LIVE_ONE_BITS   = 8'he3;
  localparam logic [REG_W-1:0] LATCH_ZERO_LVL  = 8'h1f;  // Edge-driven bits
  localparam logic [REG_W-1:0] LATCH_ONE_LVL   = 8'he3;
  localparam logic [REG_W-1:0] LATCH_TWO_LVL   = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Edge select bit positions
  localparam int ES_ALARM   = 6;
  localparam int ES_PATTERN = 5;
  localparam int ES_SHORT   = 4;
  localparam int ES_TXCLK   = 3;
  localparam int ES_TXLOSS  = 2;
  localparam int ES_LOSS    = 1;
  localparam int ES_INBAND  = 0;

  ////////////////////////////////////////////////////////////////////////
  // Decoded register selection
  typedef enum logic [3:0] {
    SEL_NONE, SEL_EDGE, SEL_MASK0, SEL_MASK1, SEL_MASK2,
    SEL_LIVE0, SEL_LIVE1, SEL_LATCH0, SEL_LATCH1, SEL_LATCH2
  } reg_sel_t;

  // Per-channel conditions from the detectors
  typedef struct packed {
    logic [REG_W-1:0] live_zero;  // Status zero layout, levels
    logic [REG_W-1:0] live_one;   // Status one layout, levels
    logic [2:0]       evt_zero;   // Amplitude, tx fifo, rx fifo pulses
    logic [5:0]       evt_two;    // Mask two layout event pulses
  } chan_cond_t;

endpackage

// file: verilog/sticky_edge_bits.sv
// Purpose: One latched interrupt status register with edge detection.
// Assumes: Inputs synchronous to ref_clk.
// Notes:   A set in the clearing cycle wins over the clear.
`timescale 1ns/1ps
`default_nettype none
module sticky_edge_bits
  import line_unit_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level_src,   // Bits driven by a live level
  input  wire logic [W-1:0] sample,      // Registered live levels
  input  wire logic [W-1:0] both_edges,  // Either edge sets the bit
  input  wire logic [W-1:0] pulse,       // Event pulses for other bits
  input  wire logic [W-1:0] clear,       // Write-one-to-clear strobes
  output logic      [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] prev;   // Live level one cycle ago
    logic [W-1:0] flags;  // Latched bits
  } sticky_state_t;

  sticky_state_t st_reg;
  sticky_state_t st_next;
  logic [W-1:0]  hit;

  // Edge detect, then set over clear
  always_comb begin
    hit = (level_src & ((sample & ~st_reg.prev) |
                        (both_edges & ~sample & st_reg.prev)))
        | (~level_src & pulse);
    st_next.prev  = sample;
    st_next.flags = (st_reg.flags & ~clear) | hit;
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;

endmodule
`default_nettype wire

// file: verilog/apb_reg_decode.sv
// Purpose: Splits an APB byte address into channel and register.
// Assumes: Word-aligned accesses; low address bits ignored.
// Notes:   Channels at or above the built count decode as unmapped.
`timescale 1ns/1ps
`default_nettype none
module apb_reg_decode
  import line_unit_pkg::*;
#(
  parameter int NCH = MAX_CHAN
) (
  input  wire logic [ADDR_W-1:0] paddr,
  output logic      [CHAN_W-1:0] chan,
  output reg_sel_t               sel
);

  // Register index to selection
  function automatic reg_sel_t idx_to_sel(input logic [REG_IDX_W-1:0] idx);
    case (idx)
      IDX_EDGE_SELECT: idx_to_sel = SEL_EDGE;
      IDX_MASK_ZERO:   idx_to_sel = SEL_MASK0;
      IDX_MASK_ONE:    idx_to_sel = SEL_MASK1;
      IDX_MASK_TWO:    idx_to_sel = SEL_MASK2;
      IDX_LIVE_ZERO:   idx_to_sel = SEL_LIVE0;
      IDX_LIVE_ONE:    idx_to_sel = SEL_LIVE1;
      IDX_LATCH_ZERO:  idx_to_sel = SEL_LATCH0;
      IDX_LATCH_ONE:   idx_to_sel = SEL_LATCH1;
      IDX_LATCH_TWO:   idx_to_sel = SEL_LATCH2;
      default:         idx_to_sel = SEL_NONE;
    endcase
  endfunction

  // Channel block, then register inside it
  always_comb begin
    chan = paddr[CHAN_LSB +: CHAN_W];
    if (32'(chan) < NCH) begin
      sel = idx_to_sel(paddr[REG_LSB +: REG_IDX_W]);
    end else begin
      sel = SEL_NONE;
    end
  end

endmodule
`default_nettype wire

// file: verilog/line_unit_interrupt_masks.sv
// Purpose: Per-channel interrupt masks, live status and latched status
//          with one combined interrupt output, behind an APB slave.
// Assumes: Detector inputs synchronous to ref_clk; APB3 signalling.
// Notes:   Reads and writes answer after one access wait cycle.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module line_unit_interrupt_masks
  import line_unit_pkg::*;
#(
  parameter int NCH = MAX_CHAN  // Channels built
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Detector conditions per channel
  input  wire chan_cond_t        chan_in [NCH],
  // Combined interrupt, active high level
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check

  generate
    if (NCH < 1 || NCH > MAX_CHAN) begin : g_bad_nch
      $error("NCH must lie between 1 and 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [NCH-1:0][REG_W-1:0] mask_zero;   // Per-channel masks
    logic [NCH-1:0][REG_W-1:0] mask_one;
    logic [NCH-1:0][REG_W-1:0] mask_two;
    logic [NCH-1:0][REG_W-1:0] edge_sel;    // Either-edge selects
    logic [NCH-1:0][REG_W-1:0] live_zero;   // Registered live status
    logic [NCH-1:0][REG_W-1:0] live_one;
    logic [DATA_W-1:0]         prdata;      // Read data
    logic                      pready;      // Access answer
    logic                      pslverr;     // Unmapped access
    logic                      irq;         // Combined interrupt
  } unit_state_t;

  unit_state_t st_reg;   // Current state
  unit_state_t st_next;  // Next state

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [CHAN_W-1:0] dec_chan;  // Addressed channel block
  reg_sel_t          dec_sel;   // Addressed register

  apb_reg_decode #(
    .NCH   (NCH)
  ) u_decode (
    .paddr (paddr),
    .chan  (dec_chan),
    .sel   (dec_sel)
  );

  // Access phase and its committing edge
  logic access;    // Access phase, answer still pending
  logic commit;    // Edge where the master samples pready
  logic wr_commit; // Write takes effect at this edge

  always_comb begin
    access    = psel && penable && !st_reg.pready;
    commit    = psel && penable && st_reg.pready;
    wr_commit = commit && pwrite;
  end

  ////////////////////////////////////////////////////////////////////////
  // Latched interrupt status, three registers per channel

  logic [NCH-1:0][REG_W-1:0] latch_zero;  // Latched bits, layout of mask 0
  logic [NCH-1:0][REG_W-1:0] latch_one;   // Layout of mask one
  logic [NCH-1:0][REG_W-1:0] latch_two;   // Layout of mask two
  logic [NCH-1:0][REG_W-1:0] clr_zero;    // Write-one-to-clear strobes
  logic [NCH-1:0][REG_W-1:0] clr_one;
  logic [NCH-1:0][REG_W-1:0] clr_two;
  logic [NCH-1:0][REG_W-1:0] both_zero;   // Either-edge per bit
  logic [NCH-1:0][REG_W-1:0] both_one;
  logic [NCH-1:0][REG_W-1:0] pulse_zero;  // Event pulses per bit
  logic [NCH-1:0][REG_W-1:0] pulse_two;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_chan
      // Clear strobes only at the committing write edge
      always_comb begin
        clr_zero[c] = '0;
        clr_one[c]  = '0;
        clr_two[c]  = '0;
        if (wr_commit && dec_chan == CHAN_W'(c)) begin
          if (dec_sel == SEL_LATCH0) begin
            clr_zero[c] = pwdata[REG_W-1:0];
          end
          if (dec_sel == SEL_LATCH1) begin
            clr_one[c] = pwdata[REG_W-1:0];
          end
          if (dec_sel == SEL_LATCH2) begin
            clr_two[c] = pwdata[REG_W-1:0];
          end
        end
      end

      // Edge selects spread onto the bits they govern
      always_comb begin
        both_zero[c] = {3'h0,
                        st_reg.edge_sel[c][ES_SHORT],
                        st_reg.edge_sel[c][ES_TXCLK],
                        st_reg.edge_sel[c][ES_TXLOSS],
                        st_reg.edge_sel[c][ES_LOSS],
                        st_reg.edge_sel[c][ES_LOSS]};
        both_one[c]  = {st_reg.edge_sel[c][ES_ALARM],
                        st_reg.edge_sel[c][ES_ALARM],
                        st_reg.edge_sel[c][ES_PATTERN],
                        3'h0,
                        st_reg.edge_sel[c][ES_INBAND],
                        st_reg.edge_sel[c][ES_INBAND]};
        pulse_zero[c] = {chan_in[c].evt_zero, 5'h00};
        pulse_two[c]  = {2'h0, chan_in[c].evt_two};
      end

      // Status zero bits 4-0 and status one drive edges
      sticky_edge_bits #(
        .W          (REG_W)
      ) u_latch_zero (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .level_src  (LATCH_ZERO_LVL),
        .sample     (st_reg.live_zero[c]),
        .both_edges (both_zero[c]),
        .pulse      (pulse_zero[c]),
        .clear      (clr_zero[c]),
        .flags      (latch_zero[c])
      );

      sticky_edge_bits #(
        .W          (REG_W)
      ) u_latch_one (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .level_src  (LATCH_ONE_LVL),
        .sample     (st_reg.live_one[c]),
        .both_edges (both_one[c]),
        .pulse      ('0),
        .clear      (clr_one[c]),
        .flags      (latch_one[c])
      );

      // Error events only, no level behind them
      sticky_edge_bits #(
        .W          (REG_W)
      ) u_latch_two (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .level_src  (LATCH_TWO_LVL),
        .sample     ('0),
        .both_edges ('0),
        .pulse      (pulse_two[c]),
        .clear      (clr_two[c]),
        .flags      (latch_two[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  logic [REG_W-1:0] rd_byte;  // Addressed register contents

  always_comb begin
    case (dec_sel)
      SEL_EDGE:   rd_byte = st_reg.edge_sel[dec_chan];
      SEL_MASK0:  rd_byte = st_reg.mask_zero[dec_chan];
      SEL_MASK1:  rd_byte = st_reg.mask_one[dec_chan];
      SEL_MASK2:  rd_byte = st_reg.mask_two[dec_chan];
      SEL_LIVE0:  rd_byte = st_reg.live_zero[dec_chan];
      SEL_LIVE1:  rd_byte = st_reg.live_one[dec_chan];
      SEL_LATCH0: rd_byte = latch_zero[dec_chan];
      SEL_LATCH1: rd_byte = latch_one[dec_chan];
      SEL_LATCH2: rd_byte = latch_two[dec_chan];
      default:    rd_byte = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Combined interrupt

  logic irq_any;  // Any unmasked latched bit in any channel

  always_comb begin
    irq_any = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      irq_any = irq_any
              | (|(latch_zero[i] & ~st_reg.mask_zero[i]))
              | (|(latch_one[i]  & ~st_reg.mask_one[i]))
              | (|(latch_two[i]  & ~st_reg.mask_two[i]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // Registers, live capture and bus answer
  always_comb begin
    st_next = st_reg;

    // Live status follows detectors one cycle later, reserved bits zero
    for (int i = 0; i < NCH; i++) begin
      // Loopback, short, clock missing and loss bits pass straight through
      st_next.live_zero[i] = chan_in[i].live_zero & LIVE_ZERO_BITS;
      st_next.live_one[i]  = chan_in[i].live_one  & LIVE_ONE_BITS;
    end

    // Writes land only at the committing edge; reserved bits keep reset
    if (wr_commit) begin
      case (dec_sel)
        SEL_EDGE: begin
          st_next.edge_sel[dec_chan] = pwdata[REG_W-1:0] & EDGE_SEL_BITS;
        end
        SEL_MASK0: begin
          st_next.mask_zero[dec_chan] = pwdata[REG_W-1:0]
                                      & MASK_ZERO_BITS;
        end
        SEL_MASK1: begin
          st_next.mask_one[dec_chan] = (pwdata[REG_W-1:0] & MASK_ONE_BITS)
                                     | (MASK_ONE_RST & ~MASK_ONE_BITS);
        end
        SEL_MASK2: begin
          st_next.mask_two[dec_chan] = pwdata[REG_W-1:0]
                                     & MASK_TWO_BITS;
        end
        default: begin
          // Status registers are read-only; latched ones clear elsewhere
          st_next.pready = st_reg.pready;
        end
      endcase
    end

    // One wait cycle, then answer for one cycle
    if (access) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (dec_sel == SEL_NONE);
      st_next.prdata  = pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, rd_byte};
    end else begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
    end

    // Interrupt level from the latched bits
    st_next.irq = irq_any;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Masks come up suppressing every source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.mask_zero <= {NCH{MASK_ZERO_RST}};
      st_reg.mask_one  <= {NCH{MASK_ONE_RST}};
      st_reg.mask_two  <= {NCH{MASK_TWO_RST}};
      st_reg.edge_sel  <= {NCH{EDGE_SELECT_RST}};
      st_reg.live_zero <= {NCH{STATUS_RST}};
      st_reg.live_one  <= {NCH{STATUS_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops

  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq     = st_reg.irq;

endmodule
`default_nettype wire

// file: verification/line_unit_interrupt_masks_props.sv
// Purpose: Port checks of the line unit interrupt mask block
// Assumes: One access wait cycle per APB transfer
// Notes:   Live read check compares with detector inputs two cycles back
`timescale 1ns/1ps
`default_nettype none
module line_unit_interrupt_masks_props
  import line_unit_pkg::*;
#(
  parameter int NCH = MAX_CHAN  // Channels built
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire chan_cond_t        chan_in [NCH],
  input wire logic              irq
);
  ////////////////////////////////////////////////////////////////////////
  logic acc;  // First access cycle
  logic hit;  // Mapped register in a built channel
  // Bus-side decode, kept apart from the design's own
  assign acc = psel && penable && !pready;
  assign hit = (paddr[7:2] inside {[6'h1a:6'h22]}) && (int'(paddr[11:8]) < NCH);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  AST_READY_LATENCY: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("pready not a one cycle pulse after access start");
  AST_READY_IDLE: assert property (!(psel && penable) |=> !pready)
    else $error("pready without an access");
  AST_HIGH_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  AST_UNMAPPED: assert property (acc && !hit |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (acc && hit |=> !pslverr)
    else $error("mapped access refused");
  AST_PRDATA_HOLD: assert property (!(psel && penable) |=> $stable(prdata))
    else $error("read data moved between accesses");
  AST_LIVE_READ: assert property (acc && !pwrite && paddr == {4'h0, IDX_LIVE_ZERO, 2'h0}
    |=> prdata[7:0] == ($past(chan_in[0].live_zero, 2) & 8'h9f))
    else $error("live status read wrong");
  AST_IRQ_RESET: assert property ($rose(rst_n) |-> !irq)
    else $error("irq high right after reset");
endmodule

bind line_unit_interrupt_masks line_unit_interrupt_masks_props #(.NCH(NCH)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan_in(chan_in), .irq(irq));
`default_nettype wire

// file: verification/tb_line_unit_interrupt_masks.sv
// Purpose: Self-checking bench of the line unit interrupt mask block
// Assumes: Two channels built; detectors driven by the bench
// Notes:   One idle cycle between transfers keeps drives unique
`timescale 1ns/1ps
`default_nettype none
module tb_line_unit_interrupt_masks
  import line_unit_pkg::*;
;
  localparam int NCH_TB = 2;      // Short map, still two channels
  logic              ref_clk;     // 40 MHz clock
  logic              rst_n;       // Async reset, active low
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  chan_cond_t        cin [NCH_TB];  // Detector conditions
  int                n_fail;
  int                num_checks;

  line_unit_interrupt_masks #(.NCH(NCH_TB)) u_line_unit_interrupt_masks (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_in(cin), .irq(irq));

  // Free-running clock
  always #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered right after a rising edge
  task automatic apb(input logic wr, input logic [3:0] ch, input logic [5:0] idx,
                     input logic [7:0] d, output logic [DATA_W-1:0] rd, output logic err);
    int n;
    n = 0;
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= {ch, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    // Bounded wait, the slave sets the pace
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      n_fail++;
      end_of_test();
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] ch, input logic [5:0] idx, input logic [7:0] d);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'h1, ch, idx, d, rd, err);
  endtask

  task automatic rdc(input logic [3:0] ch, input logic [5:0] idx, input logic [7:0] exp,
                     input logic e);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'h0, ch, idx, 8'h00, rd, err);
    chk_val(rd, {24'h0, exp});
    chk_bit(err, e);
  endtask

  // Irq level after a settling wait of k edges
  task automatic irq_is(input int k, input logic e);
    repeat (k) @(posedge ref_clk);
    chk_bit(irq, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int c = 0; c < NCH_TB; c++) begin
      rdc(4'(c), IDX_MASK_ZERO, 8'hff, 1'h0);
      rdc(4'(c), IDX_MASK_ONE, 8'hef, 1'h0);
      rdc(4'(c), IDX_MASK_TWO, 8'h3f, 1'h0);
      rdc(4'(c), IDX_LIVE_ZERO, 8'h00, 1'h0);
    end
    chk_bit(irq, 1'h0);
    $display("reset values done");
  endtask

  task automatic t_mask_rw;
    wr(4'h0, IDX_MASK_ZERO, 8'h5a);
    rdc(4'h0, IDX_MASK_ZERO, 8'h5a, 1'h0);
    rdc(4'h1, IDX_MASK_ZERO, 8'hff, 1'h0);
    wr(4'h0, IDX_MASK_ONE, 8'h00);
    rdc(4'h0, IDX_MASK_ONE, 8'h0c, 1'h0);
    wr(4'h0, IDX_MASK_TWO, 8'hff);
    rdc(4'h0, IDX_MASK_TWO, 8'h3f, 1'h0);
    wr(4'h0, IDX_MASK_TWO, 8'h00);
    rdc(4'h0, IDX_MASK_TWO, 8'h00, 1'h0);
    $display("mask access done");
  endtask

  // Walking one over status zero, the other channel inverted
  task automatic t_status;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      cin[0].live_zero <= v;
      cin[1].live_zero <= ~v;
      @(posedge ref_clk);
      rdc(4'h0, IDX_LIVE_ZERO, v & 8'h9f, 1'h0);
      rdc(4'h1, IDX_LIVE_ZERO, ~v & 8'h9f, 1'h0);
    end
    wr(4'h0, IDX_LIVE_ZERO, 8'h00);
    rdc(4'h0, IDX_LIVE_ZERO, 8'h80, 1'h0);
    cin[0].live_zero <= 8'h00;
    cin[1].live_zero <= 8'h00;
    @(posedge ref_clk);
    $display("status done");
  endtask

  // Refusals: hole in the map, channel not built
  task automatic t_refuse;
    rdc(4'h0, 6'h30, 8'h00, 1'h1);
    wr(4'h2, IDX_MASK_ZERO, 8'h00);
    rdc(4'h2, IDX_MASK_ZERO, 8'h00, 1'h1);
    rdc(4'h0, IDX_MASK_ZERO, 8'h5a, 1'h0);
    $display("refusal done");
  endtask

  task automatic t_irq;
    wr(4'h0, IDX_MASK_ZERO, 8'hff);
    wr(4'h0, IDX_MASK_TWO, 8'h3f);
    for (int c = 0; c < NCH_TB; c++) begin
      wr(4'(c), IDX_LATCH_ZERO, 8'hff);
      wr(4'(c), IDX_LATCH_ONE, 8'hff);
      wr(4'(c), IDX_LATCH_TWO, 8'hff);
    end
    irq_is(3, 1'h0);
    cin[1].live_zero[0] <= 1'h1;
    irq_is(4, 1'h0);
    wr(4'h1, IDX_MASK_ZERO, 8'hfe);
    irq_is(3, 1'h1);
    wr(4'h1, IDX_LATCH_ZERO, 8'h01);
    irq_is(2, 1'h0);
    wr(4'h1, IDX_EDGE_SELECT, 8'h02);
    cin[1].live_zero[0] <= 1'h0;
    irq_is(4, 1'h1);
    wr(4'h1, IDX_LATCH_ZERO, 8'h01);
    irq_is(2, 1'h0);
    wr(4'h0, IDX_MASK_ONE, 8'hee);
    cin[0].live_one[0] <= 1'h1;
    irq_is(4, 1'h1);
    wr(4'h0, IDX_LATCH_ONE, 8'h01);
    irq_is(2, 1'h0);
    wr(4'h0, IDX_MASK_TWO, 8'h3e);
    cin[0].evt_two[0] <= 1'h1;
    @(posedge ref_clk);
    cin[0].evt_two[0] <= 1'h0;
    irq_is(3, 1'h1);
    wr(4'h0, IDX_LATCH_TWO, 8'h01);
    irq_is(2, 1'h0);
    $display("interrupt done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    ref_clk = 1'h0;
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cin = '{default: '0};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    t_reset();
    t_mask_rw();
    t_status();
    t_refuse();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
